// [fcsl_regs.svh]
`ifndef FCSL_REGS_SVH
`define FCSL_REGS_SVH

// Register indices; byte address is four times the index
`define FCSL_IDX_CONFIG 12'h103
`define FCSL_IDX_STATUS 12'h105
`define FCSL_IDX_COMMAND 12'h106

// Status bit positions
`define FCSL_ST_BUF_EMPTY 7
`define FCSL_ST_CMD_DONE 6
`define FCSL_ST_PROT_VIOL 5
`define FCSL_ST_ACC_ERR 4
`define FCSL_ST_ERASED 2
`define FCSL_ST_FAILED 1

// Config bit positions
`define FCSL_CF_BE_IRQ_EN 7
`define FCSL_CF_CC_IRQ_EN 6

// Reset values
`define FCSL_STATUS_RESET 8'hc0
`define FCSL_CONFIG_RESET 8'h00
`define FCSL_COMMAND_RESET 7'h00

// Command codes
`define FCSL_CMD_ERASE_VERIFY 7'h05
`define FCSL_CMD_PROGRAM 7'h20
`define FCSL_CMD_BURST_PROGRAM 7'h25
`define FCSL_CMD_SECTOR_ERASE 7'h40
`define FCSL_CMD_ARRAY_ERASE 7'h41

`endif

// [fcsl_pkg.sv]
package fcsl_pkg;

    typedef enum logic [1:0] {
        seq_idle,
        seq_addr,
        seq_cmd
    } fcsl_seq_type;

    typedef struct packed {
        fcsl_seq_type seq;
        logic buffer_empty_flag;
        logic command_complete_flag;
        logic protection_violation_flag;
        logic access_error_flag;
        logic erased_flag;
        logic failed_flag;
        logic buffer_empty_irq_enable;
        logic command_complete_irq_enable;
        logic [6:0] command_code;
        logic pend_valid;
        logic [6:0] pend_code;
        logic active_valid;
        logic [6:0] active_code;
        logic launch;
        logic [6:0] launch_code;
        logic seq_abort;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } fcsl_state_type;

endpackage

// [fcsl_top.sv]
`timescale 1ns/1ns
`include "fcsl_regs.svh"
// What this block does
// - Buffer-empty flag shows command buffer free
// - Writing one clears flag, launches command
// - Zero write mid-sequence aborts, sets error
// - Zero write outside sequence is harmless
// - Interrupt on buffer-empty with enable
// - Complete flag clears on launch, self-sets
// - Complete stays low when burst continues
// - Interrupt on command-complete with enable
// - Protected target sets violation; one clears
// - Violation blocks launches and new sequences
// - Sequence, code, stop errors set access error
// - Access error clears on one, blocks work
// - Erased flag holds erase-verify result
// - New valid launch clears erased flag
// - Erased flag write-one clear only in special mode
// - Special mode failed flag on bad verify
// - Status resets to flags one, others zero
// - Seven-bit command field, top bit zero
// - Decode verify, program, burst program codes
// - Decode sector and whole-array erase codes
// - Unknown code in normal mode: access error
module fcsl_top #(
    parameter int ADDR_WIDTH = 14
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic special_mode,
    input wire logic array_write,
    input wire logic array_addr_aligned,
    input wire logic array_addr_protected,
    input wire logic cpu_stop,
    input wire logic engine_done,
    input wire logic verify_erased,
    output logic cmd_launch,
    output logic [6:0] cmd_launch_code,
    output logic seq_abort,
    output logic irq
);

    initial begin
        if (ADDR_WIDTH < 14 || ADDR_WIDTH > 32) begin
            $error("fcsl_top: ADDR_WIDTH must be 14 to 32");
        end
    end

    fcsl_pkg::fcsl_state_type st;
    fcsl_pkg::fcsl_state_type next_st;

    function automatic logic fcsl_code_valid(input logic [6:0] code);
        fcsl_code_valid = (code == `FCSL_CMD_ERASE_VERIFY) || (code == `FCSL_CMD_PROGRAM) ||
                          (code == `FCSL_CMD_BURST_PROGRAM) || (code == `FCSL_CMD_SECTOR_ERASE) ||
                          (code == `FCSL_CMD_ARRAY_ERASE);
    endfunction

    function automatic logic fcsl_hit(input logic [ADDR_WIDTH-1:0] adr, input logic [11:0] idx);
        fcsl_hit = (adr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx)) && (adr[1:0] == 2'b00);
    endfunction

    logic bus_req;
    logic bus_wr;
    logic lane0;
    logic hit_cfg;
    logic hit_stat;
    logic hit_cmd;
    logic [7:0] wbyte;
    logic [7:0] status_view;
    logic blocked;

    assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign lane0 = wb_sel_i[0];
    assign hit_cfg = fcsl_hit(wb_adr_i, `FCSL_IDX_CONFIG);
    assign hit_stat = fcsl_hit(wb_adr_i, `FCSL_IDX_STATUS);
    assign hit_cmd = fcsl_hit(wb_adr_i, `FCSL_IDX_COMMAND);
    assign wbyte = wb_dat_i[7:0];
    assign blocked = st.protection_violation_flag || st.access_error_flag;

    always_comb begin
        status_view = 8'h00;
        status_view[`FCSL_ST_BUF_EMPTY] = st.buffer_empty_flag;
        status_view[`FCSL_ST_CMD_DONE] = st.command_complete_flag;
        status_view[`FCSL_ST_PROT_VIOL] = st.protection_violation_flag;
        status_view[`FCSL_ST_ACC_ERR] = st.access_error_flag;
        status_view[`FCSL_ST_ERASED] = st.erased_flag;
        status_view[`FCSL_ST_FAILED] = special_mode && st.failed_flag;
    end

    always_comb begin
        logic set_acc;
        logic set_pv;
        logic abort;
        logic do_launch;
        logic engine_free;
        set_acc = 1'b0;
        set_pv = 1'b0;
        abort = 1'b0;
        do_launch = 1'b0;
        engine_free = 1'b0;
        next_st = st;
        next_st.launch = 1'b0;
        next_st.seq_abort = 1'b0;

        // Bus handshake: ack one cycle after request, dropped next cycle
        next_st.ack = bus_req;
        next_st.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_i && lane0) begin
            if (hit_cfg) begin
                next_st.rdata[`FCSL_CF_BE_IRQ_EN] = st.buffer_empty_irq_enable;
                next_st.rdata[`FCSL_CF_CC_IRQ_EN] = st.command_complete_irq_enable;
            end else if (hit_stat) begin
                next_st.rdata[7:0] = status_view;
            end else if (hit_cmd) begin
                next_st.rdata[7:0] = {1'b0, st.command_code};
            end
        end

        if (bus_wr && hit_cfg) begin
            next_st.buffer_empty_irq_enable = wbyte[`FCSL_CF_BE_IRQ_EN];
            next_st.command_complete_irq_enable = wbyte[`FCSL_CF_CC_IRQ_EN];
        end

        // Array writes are ignored while blocked; otherwise they open a sequence, or set an error and abort if misplaced
        if (array_write) begin
            if (blocked) begin
                abort = 1'b0;
            end else if (st.seq != fcsl_pkg::seq_idle || !st.buffer_empty_flag || !array_addr_aligned) begin
                set_acc = 1'b1;
                abort = 1'b1;
            end else if (array_addr_protected) begin
                set_pv = 1'b1;
                abort = 1'b1;
            end else begin
                next_st.seq = fcsl_pkg::seq_addr;
            end
        end

        if (bus_wr && hit_cmd) begin
            if (st.seq == fcsl_pkg::seq_addr && !blocked) begin
                next_st.command_code = wbyte[6:0];
                if (!special_mode && !fcsl_code_valid(wbyte[6:0])) begin
                    set_acc = 1'b1;
                    abort = 1'b1;
                end else begin
                    next_st.seq = fcsl_pkg::seq_cmd;
                end
            end else if (!blocked) begin
                set_acc = 1'b1;
                abort = 1'b1;
            end
        end

        if (bus_wr && hit_stat) begin
            if (wbyte[`FCSL_ST_BUF_EMPTY]) begin
                if (st.seq == fcsl_pkg::seq_cmd && !blocked) begin
                    do_launch = 1'b1;
                end else if (st.seq != fcsl_pkg::seq_idle) begin
                    set_acc = 1'b1;
                    abort = 1'b1;
                end
            end else if (st.seq != fcsl_pkg::seq_idle) begin
                set_acc = 1'b1;
                abort = 1'b1;
            end
            if (wbyte[`FCSL_ST_PROT_VIOL]) begin
                next_st.protection_violation_flag = 1'b0;
            end
            if (wbyte[`FCSL_ST_ACC_ERR]) begin
                next_st.access_error_flag = 1'b0;
            end
            if (special_mode && wbyte[`FCSL_ST_ERASED]) begin
                next_st.erased_flag = 1'b0;
            end
            if (special_mode && wbyte[`FCSL_ST_FAILED]) begin
                next_st.failed_flag = 1'b0;
            end
        end

        if (cpu_stop && !st.command_complete_flag) begin
            set_acc = 1'b1;
        end

        if (abort) begin
            next_st.seq = fcsl_pkg::seq_idle;
            next_st.seq_abort = 1'b1;
        end

        if (do_launch) begin
            next_st.seq = fcsl_pkg::seq_idle;
            next_st.buffer_empty_flag = 1'b0;
            next_st.command_complete_flag = 1'b0;
            next_st.erased_flag = 1'b0;
            next_st.pend_valid = 1'b1;
            next_st.pend_code = st.command_code;
        end

        // Engine side: finish active, then pull pending
        engine_free = !st.active_valid;
        if (st.active_valid && engine_done) begin
            engine_free = 1'b1;
            next_st.active_valid = 1'b0;
            if (st.active_code == `FCSL_CMD_ERASE_VERIFY) begin
                next_st.erased_flag = verify_erased;
                if (special_mode && !verify_erased) begin
                    next_st.failed_flag = 1'b1;
                end
            end
            if (!st.pend_valid && !do_launch) begin
                // All work finished, nothing just buffered
                next_st.command_complete_flag = 1'b1;
            end
        end
        if (st.pend_valid && engine_free) begin
            next_st.pend_valid = 1'b0;
            next_st.active_valid = 1'b1;
            next_st.active_code = st.pend_code;
            next_st.launch = 1'b1;
            next_st.launch_code = st.pend_code;
            next_st.buffer_empty_flag = 1'b1;
            next_st.command_complete_flag = 1'b0;
        end

        // Hardware set wins over software clear
        if (set_acc) begin
            next_st.access_error_flag = 1'b1;
        end
        if (set_pv) begin
            next_st.protection_violation_flag = 1'b1;
        end

        next_st.irq = (next_st.buffer_empty_flag && next_st.buffer_empty_irq_enable) ||
                      (next_st.command_complete_flag && next_st.command_complete_irq_enable);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            next_st_reset();
        end else begin
            st <= next_st;
        end
    end

    task automatic next_st_reset();
        st.seq <= fcsl_pkg::seq_idle;
        {st.buffer_empty_flag, st.command_complete_flag, st.protection_violation_flag,
         st.access_error_flag} <= 4'(`FCSL_STATUS_RESET >> 4);
        st.erased_flag <= 1'b0;
        st.failed_flag <= 1'b0;
        st.buffer_empty_irq_enable <= 1'b0;
        st.command_complete_irq_enable <= 1'b0;
        st.command_code <= `FCSL_COMMAND_RESET;
        st.pend_valid <= 1'b0;
        st.pend_code <= `FCSL_COMMAND_RESET;
        st.active_valid <= 1'b0;
        st.active_code <= `FCSL_COMMAND_RESET;
        st.launch <= 1'b0;
        st.launch_code <= `FCSL_COMMAND_RESET;
        st.seq_abort <= 1'b0;
        st.ack <= 1'b0;
        st.rdata <= 32'h0000_0000;
        st.irq <= 1'b0;
    endtask

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign cmd_launch = st.launch;
    assign cmd_launch_code = st.launch_code;
    assign seq_abort = st.seq_abort;
    assign irq = st.irq;

endmodule

// [fcsl_engine.sv]
`timescale 1ns/1ns
module fcsl_engine (
    input wire logic clk,
    input wire logic srst,
    input wire logic launch,
    input wire logic slow,
    input wire logic blank,
    output logic done,
    output logic erased
);
    int cnt;
    // Busy time, short or long
    always @(posedge clk) begin
        done <= 1'b0;
        if (srst)
            cnt <= 0;
        else if (launch)
            cnt <= slow ? 40 : 2;
        else if (cnt == 1) begin
            cnt <= 0;
            done <= 1'b1;
        end else if (cnt > 1)
            cnt <= cnt - 1;
    end
    // Result only valid with done
    assign erased = done ? blank : !blank;
endmodule

// [fcsl_props.sv]
`timescale 1ns/1ns
module fcsl_props #(
    parameter int ADDR_WIDTH = 14
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic special_mode,
    input wire logic array_write,
    input wire logic array_addr_aligned,
    input wire logic array_addr_protected,
    input wire logic cpu_stop,
    input wire logic engine_done,
    input wire logic verify_erased,
    input wire logic cmd_launch,
    input wire logic [6:0] cmd_launch_code,
    input wire logic seq_abort,
    input wire logic irq
);
    logic take, wr, go, cf_off;
    assign take = wb_cyc_i & wb_stb_i & !wb_ack_o;
    assign wr = take & wb_we_i & wb_sel_i[0];
    assign go = wr & wb_dat_i[7] & (wb_adr_i == 14'h414);
    assign cf_off = wr & (wb_dat_i[7:6] == 2'b00) & (wb_adr_i == 14'h40c);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_req;
        take;
    endsequence
    sequence s_cfg_off;
        cf_off ##1 1'b1;
    endsequence
    property p_ack_once;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
    property p_hi_zero;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
    property p_launch_cause;
        cmd_launch |-> $past(go, 2) || $past(engine_done);
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("launch without cause");
    property p_code_ok;
        cmd_launch && !special_mode |-> cmd_launch_code inside {7'h05, 7'h20, 7'h25, 7'h40, 7'h41};
    endproperty
    a_code_ok: assert property (p_code_ok) else $error("illegal code launched");
    property p_code_hold;
        !cmd_launch ##1 !cmd_launch |-> $stable(cmd_launch_code);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("launch code moved");
    property p_abort_cause;
        seq_abort |-> $past(wr) || $past(array_write);
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort without access");
    property p_irq_off;
        s_cfg_off |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
    property p_rst;
        disable iff (1'b0) srst |=> !wb_ack_o && !cmd_launch && !seq_abort && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("output active after reset");
endmodule
bind fcsl_top fcsl_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
    .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .special_mode, .array_write, .array_addr_aligned, .array_addr_protected,
    .cpu_stop, .engine_done, .verify_erased, .cmd_launch, .cmd_launch_code, .seq_abort, .irq
);

// [tb_fcsl_top.sv]
`timescale 1ns/1ns
`include "fcsl_regs.svh"
module tb_fcsl_top;
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, aw = 0, prot = 0, stp = 0, sm = 0, blank = 1, aln = 1;
    logic [13:0] adr = '0;
    logic [31:0] wd = '0, dato, rd;
    logic ack, go, ab, irq, done, ver;
    logic [6:0] gc;
    logic [6:0] lq[$];
    logic [6:0] codes[5] = '{7'h05, 7'h20, 7'h25, 7'h40, 7'h41};
    int bad_count = 0, tests_run = 0, seed = 32'h493fa268, na = 0, ex;
    fcsl_top dut_u (
        .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack), .special_mode(sm),
        .array_write(aw), .array_addr_aligned(aln), .array_addr_protected(prot), .cpu_stop(stp),
        .engine_done(done), .verify_erased(ver), .cmd_launch(go), .cmd_launch_code(gc),
        .seq_abort(ab), .irq(irq)
    );
    fcsl_engine u_eng (
        .clk(clk), .srst(srst), .launch(go), .slow(1'b1), .blank(blank), .done(done), .erased(ver)
    );
    always #25 clk = ~clk;
    always @(negedge clk) begin
        if (go === 1'b1)
            lq.push_back(gc);
        if (ab === 1'b1)
            na++;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rs(input logic [31:0] exp);
        bus(1'b0, `FCSL_IDX_STATUS, 8'h00);
        chk(rd, exp);
    endtask
    task automatic arr(input logic p);
        aw <= 1'b1;
        prot <= p;
        @(posedge clk);
        aw <= 1'b0;
        prot <= 1'b0;
        @(posedge clk);
    endtask
    task automatic seq(input logic [6:0] c);
        arr(1'b0);
        bus(1'b1, `FCSL_IDX_COMMAND, {1'b0, c});
        bus(1'b1, `FCSL_IDX_STATUS, 8'h80);
    endtask
    task automatic wbit(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, `FCSL_IDX_STATUS, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 30);
        if (rd[b] !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rs(32'hc0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h4f);
        rs(32'hc0);
        bus(1'b0, 12'h107, 8'h00);
        chk(rd, 32'h0);
        bus(1'b1, `FCSL_IDX_CONFIG, 8'hc0);
        chk(irq, 32'h1);
        bus(1'b0, `FCSL_IDX_CONFIG, 8'h00);
        chk(rd, 32'hc0);
        bus(1'b1, `FCSL_IDX_CONFIG, 8'h00);
        chk(irq, 32'h0);
        foreach (codes[k]) begin
            blank <= 1'($random(seed));
            seq(codes[k]);
            rs(32'h80);
            chk(lq.pop_front(), codes[k]);
            wbit(6);
            ex = (codes[k] == `FCSL_CMD_ERASE_VERIFY && blank) ? 'hc4 : 'hc0;
            chk(rd, ex);
        end
        seq(7'h60 | (7'($random(seed)) & 7'h0f));
        rs(32'hd0);
        seq(`FCSL_CMD_PROGRAM);
        chk(lq.size(), 0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h10);
        rs(32'hc0);
        ex = na;
        arr(1'b0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h00);
        rs(32'hd0);
        chk(na, ex + 1);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h10);
        arr(1'b1);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h00);
        seq(`FCSL_CMD_PROGRAM);
        rs(32'he0);
        chk(lq.size(), 0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h20);
        rs(32'hc0);
        aln <= 1'b0;
        arr(1'b0);
        aln <= 1'b1;
        rs(32'hd0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h10);
        seq(`FCSL_CMD_SECTOR_ERASE);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        rs(32'h90);
        wbit(6);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h10);
        lq.delete();
        seq(`FCSL_CMD_BURST_PROGRAM);
        seq(`FCSL_CMD_BURST_PROGRAM);
        rs(32'h00);
        wbit(7);
        chk(rd, 32'h80);
        wbit(6);
        chk(lq.size(), 2);
        sm <= 1'b1;
        blank <= 1'b0;
        seq(`FCSL_CMD_ERASE_VERIFY);
        wbit(6);
        chk(rd, 32'hc2);
        sm <= 1'b0;
        rs(32'hc0);
        sm <= 1'b1;
        bus(1'b1, `FCSL_IDX_STATUS, 8'h02);
        blank <= 1'b1;
        seq(`FCSL_CMD_ERASE_VERIFY);
        wbit(6);
        chk(rd, 32'hc4);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h04);
        rs(32'hc0);
        bus(1'b1, `FCSL_IDX_CONFIG, 8'hc0);
        arr(1'b0);
        bus(1'b1, `FCSL_IDX_STATUS, 8'h00);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(irq, 32'h0);
        rs(32'hc0);
        wrap_up();
    end
endmodule
